// *** coprocessor_host_serial_port.sv ***
// Host serial port: I2C or SPI slave front end of the coprocessor.
// Assumes the core drains instruction bytes and offers result bytes
// on clk_sys; the host clock pin also clocks the SPI shifter.
`timescale 1ns/1ps
`default_nettype none
module coprocessor_host_serial_port #(
  parameter int SPI_RESET_COUNT = fpu_port_pkg::SPI_RESET_CYCLES,
  parameter int DEPTH = fpu_port_pkg::BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic linkClk,
  input wire logic csPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic serialOutPin,
  input wire logic [6:0] nvAddr,
  input wire logic nvAddrValid,
  output logic [7:0] instrData,
  output logic instrValid,
  input wire logic instrTake,
  input wire logic [7:0] resultData,
  input wire logic resultValid,
  output logic resultTake,
  input wire logic coreBusy,
  input wire logic traceEmpty,
  input wire logic debugActive,
  output logic deviceReset,
  output logic [31:0] regInitWord,
  output logic i2cMode
);
  import fpu_port_pkg::*;
  localparam int CW = $clog2(DEPTH) + 1;
  localparam logic [7:0] DEPTH8 = 8'(DEPTH);
  localparam logic [31:0] SPI_LAST = 32'(SPI_RESET_COUNT - 1);

  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncOut;
  logic csS;
  logic sclS;
  logic sdaS;
  logic togS;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  logic togPrev_reg;
  logic [1:0] modeWait_reg;
  logic i2cMode_reg;
  logic modeReady;
  logic i2cActive;
  logic [6:0] slaveAddr_reg;
  i2c_state_e state_reg;
  logic [2:0] bitCnt_reg;
  logic gotByte_reg;
  logic [7:0] shift_reg;
  logic [7:0] txShift_reg;
  logic rw_reg;
  logic ackSeen_reg;
  logic firstByte_reg;
  logic [7:0] regPtr_reg;
  logic sdaOe_reg;
  logic pushI2c_reg;
  logic rstI2c_reg;
  logic resultTake_reg;
  logic [7:0] readByte;
  logic readTakesResult;
  logic [2:0] linkBits_reg;
  logic [7:0] linkShift_reg;
  logic [7:0] spiByte_reg;
  logic spiTog_reg;
  logic linkRst_n;
  logic spiPush;
  logic [31:0] spiCnt_reg;
  logic spiArmed_reg;
  logic spiRstFire;
  logic deviceReset_reg;
  logic serialOut_reg;
  logic [31:0] regInit_reg;
  logic pushValid;
  logic [7:0] pushData;
  logic [CW-1:0] fifoCount;
  logic [7:0] freeSpace;
  logic busyNow;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;

  // Pin synchronisation
  assign syncIn = {spiTog_reg, sdaIn, linkClk, csPin};
  sync_2ff #(.WIDTH(SYNC_W)) u_sync (
    .clk(clk_sys),
    .rst_n(rst_n),
    .d(syncIn),
    .q(syncOut)
  );
  assign csS = syncOut[SYNC_CS];
  assign sclS = syncOut[SYNC_SCL];
  assign sdaS = syncOut[SYNC_SDA];
  assign togS = syncOut[SYNC_TOG];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclPrev_reg <= 1'b0;
      sdaPrev_reg <= 1'b0;
      togPrev_reg <= 1'b0;
    end else begin
      sclPrev_reg <= sclS;
      sdaPrev_reg <= sdaS;
      togPrev_reg <= togS;
    end
  end
  assign sclRise = sclS & ~sclPrev_reg;
  assign sclFall = ~sclS & sclPrev_reg;
  assign startDet = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
  assign stopDet = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;

  // Interface strap caught once the synchroniser has settled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      modeWait_reg <= 2'h0;
      i2cMode_reg <= 1'b1;
    end else if (modeWait_reg != MODE_WAIT_DONE) begin
      modeWait_reg <= modeWait_reg + 2'h1;
      if (modeWait_reg == MODE_WAIT_TAKE) begin
        i2cMode_reg <= csS;
      end
    end
  end
  assign modeReady = (modeWait_reg == MODE_WAIT_DONE);
  assign i2cActive = modeReady & i2cMode_reg;

  // Slave address from nonvolatile store
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slaveAddr_reg <= I2C_ADDR_DEFAULT;
    end else if (nvAddrValid) begin
      slaveAddr_reg <= nvAddr;
    end
  end

  // Read data selection
  assign freeSpace = DEPTH8 - 8'(fifoCount);
  assign busyNow = (fifoCount != '0) | coreBusy | ~traceEmpty | debugActive;
  always_comb begin
    readTakesResult = 1'b0;
    readByte = OTHER_READ;
    if (regPtr_reg == REG_DATA) begin
      if (resultValid) begin
        readByte = resultData;
        readTakesResult = 1'b1;
      end else begin
        readByte = busyNow ? STATUS_BUSY : STATUS_READY;
      end
    end else if (regPtr_reg == REG_CTRL) begin
      readByte = freeSpace;
    end
  end

  // I2C slave protocol
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 3'h0;
      gotByte_reg <= 1'b0;
      shift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      rw_reg <= 1'b0;
      ackSeen_reg <= 1'b0;
      firstByte_reg <= 1'b0;
      regPtr_reg <= REG_DATA;
      sdaOe_reg <= 1'b0;
      pushI2c_reg <= 1'b0;
      rstI2c_reg <= 1'b0;
      resultTake_reg <= 1'b0;
    end else begin
      pushI2c_reg <= 1'b0;
      rstI2c_reg <= 1'b0;
      resultTake_reg <= 1'b0;
      if (!i2cActive) begin
        state_reg <= ST_IDLE;
        sdaOe_reg <= 1'b0;
      end else if (startDet) begin
        state_reg <= ST_ADDR;
        bitCnt_reg <= 3'h0;
        gotByte_reg <= 1'b0;
        sdaOe_reg <= 1'b0;
      end else if (stopDet) begin
        state_reg <= ST_IDLE;
        sdaOe_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            sdaOe_reg <= 1'b0;
          end
          ST_ADDR, ST_RXB: begin
            if (sclRise) begin
              shift_reg <= {shift_reg[6:0], sdaS};
              bitCnt_reg <= bitCnt_reg + 3'h1;
              gotByte_reg <= (bitCnt_reg == 3'h7);
            end else if (sclFall && gotByte_reg) begin
              gotByte_reg <= 1'b0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == slaveAddr_reg) begin
                  rw_reg <= shift_reg[0];
                  sdaOe_reg <= 1'b1;
                  state_reg <= ST_ADDR_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                sdaOe_reg <= 1'b1;
                state_reg <= ST_RXACK;
                firstByte_reg <= 1'b0;
                if (firstByte_reg) begin
                  regPtr_reg <= shift_reg;
                end else if (regPtr_reg == REG_DATA) begin
                  pushI2c_reg <= 1'b1;
                end else if (regPtr_reg == REG_CTRL && shift_reg == RESET_BYTE) begin
                  rstI2c_reg <= 1'b1;
                end
              end
            end
          end
          ST_ADDR_ACK: begin
            if (sclFall) begin
              bitCnt_reg <= 3'h0;
              if (rw_reg) begin
                txShift_reg <= readByte;
                sdaOe_reg <= ~readByte[7];
                resultTake_reg <= readTakesResult;
                state_reg <= ST_TXB;
              end else begin
                sdaOe_reg <= 1'b0;
                firstByte_reg <= 1'b1;
                state_reg <= ST_RXB;
              end
            end
          end
          ST_RXACK: begin
            if (sclFall) begin
              sdaOe_reg <= 1'b0;
              bitCnt_reg <= 3'h0;
              state_reg <= ST_RXB;
            end
          end
          ST_TXB: begin
            if (sclFall) begin
              bitCnt_reg <= bitCnt_reg + 3'h1;
              if (bitCnt_reg == 3'h7) begin
                sdaOe_reg <= 1'b0;
                state_reg <= ST_TXACK;
              end else begin
                txShift_reg <= {txShift_reg[6:0], 1'b0};
                sdaOe_reg <= ~txShift_reg[6];
              end
            end
          end
          ST_TXACK: begin
            if (sclRise) begin
              ackSeen_reg <= ~sdaS;
            end else if (sclFall) begin
              bitCnt_reg <= 3'h0;
              if (ackSeen_reg) begin
                txShift_reg <= readByte;
                sdaOe_reg <= ~readByte[7];
                resultTake_reg <= readTakesResult;
                state_reg <= ST_TXB;
              end else begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            sdaOe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // SPI shifter on the host clock, cleared while a reset is armed
  assign linkRst_n = rst_n & ~spiArmed_reg;
  always_ff @(posedge linkClk or negedge linkRst_n) begin
    if (!linkRst_n) begin
      linkBits_reg <= 3'h0;
      linkShift_reg <= 8'h00;
    end else begin
      linkShift_reg <= {linkShift_reg[6:0], sdaIn};
      linkBits_reg <= linkBits_reg + 3'h1;
    end
  end
  always_ff @(posedge linkClk or negedge rst_n) begin
    if (!rst_n) begin
      spiByte_reg <= 8'h00;
      spiTog_reg <= 1'b0;
    end else if (linkBits_reg == 3'h7) begin
      spiByte_reg <= {linkShift_reg[6:0], sdaIn};
      spiTog_reg <= ~spiTog_reg;
    end
  end
  assign spiPush = modeReady & ~i2cMode_reg & (togS ^ togPrev_reg);

  // SPI reset pattern detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      spiCnt_reg <= 32'h0;
      spiArmed_reg <= 1'b0;
    end else if (!modeReady || i2cMode_reg) begin
      spiCnt_reg <= 32'h0;
      spiArmed_reg <= 1'b0;
    end else if (spiArmed_reg) begin
      spiCnt_reg <= 32'h0;
      if (!sclS) begin
        spiArmed_reg <= 1'b0;
      end
    end else if (sclS && !sdaS) begin
      if (spiCnt_reg == SPI_LAST) begin
        spiArmed_reg <= 1'b1;
      end else begin
        spiCnt_reg <= spiCnt_reg + 32'h1;
      end
    end else begin
      spiCnt_reg <= 32'h0;
    end
  end
  assign spiRstFire = spiArmed_reg & ~sclS;

  // Device reset pulse and register initial value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      deviceReset_reg <= 1'b0;
      regInit_reg <= NAN_INIT;
    end else begin
      deviceReset_reg <= rstI2c_reg | spiRstFire;
      regInit_reg <= NAN_INIT;
    end
  end

  // Busy indication on the serial output pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serialOut_reg <= 1'b0;
    end else begin
      serialOut_reg <= busyNow;
    end
  end

  // Instruction buffer
  assign pushValid = pushI2c_reg | spiPush;
  assign pushData = pushI2c_reg ? shift_reg : spiByte_reg;
  instr_buffer #(.WIDTH(8), .DEPTH(DEPTH)) u_buf (
    .clk(clk_sys),
    .rst_n(rst_n),
    .flush(deviceReset_reg),
    .wrData(pushData),
    .wrValid(pushValid),
    .rdData(instrData),
    .rdValid(instrValid),
    .rdReady(instrTake),
    .count(fifoCount)
  );

  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_reg;
  assign serialOutPin = serialOut_reg;
  assign resultTake = resultTake_reg;
  assign deviceReset = deviceReset_reg;
  assign regInitWord = regInit_reg;
  assign i2cMode = i2cMode_reg;

  // Checks
  sequence s_armed_fall;
    spiArmed_reg && !sclS;
  endsequence
  sequence s_reset_write;
    state_reg == ST_RXB && sclFall && gotByte_reg && !firstByte_reg
      && regPtr_reg == REG_CTRL && shift_reg == RESET_BYTE && i2cActive
      && !startDet && !stopDet;
  endsequence
  property p_start_addr;
    @(posedge clk_sys) disable iff (!rst_n)
      (i2cActive && startDet) |=> (state_reg == ST_ADDR && bitCnt_reg == 3'h0);
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");
  property p_addr_miss;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_reg == ST_ADDR && sclFall && gotByte_reg && i2cActive && !startDet
        && !stopDet && shift_reg[7:1] != slaveAddr_reg)
      |=> (state_reg == ST_IDLE && !sdaOe_reg);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");
  property p_reset_write;
    @(posedge clk_sys) disable iff (!rst_n)
      s_reset_write |=> rstI2c_reg ##1 deviceReset_reg;
  endproperty
  a_reset_write: assert property (p_reset_write) else $error("reset write lost");
  property p_spi_reset;
    @(posedge clk_sys) disable iff (!rst_n)
      s_armed_fall |=> (deviceReset_reg && !spiArmed_reg);
  endproperty
  a_spi_reset: assert property (p_spi_reset) else $error("spi reset not fired");
  property p_spi_cause;
    @(posedge clk_sys) disable iff (!rst_n)
      (deviceReset_reg && !$past(rstI2c_reg)) |-> $past(spiArmed_reg);
  endproperty
  a_spi_cause: assert property (p_spi_cause) else $error("reset without cause");
  property p_busy_push;
    @(posedge clk_sys) disable iff (!rst_n)
      (pushValid && fifoCount != CW'(DEPTH) && !deviceReset_reg) |-> ##2 serialOut_reg;
  endproperty
  a_busy_push: assert property (p_busy_push) else $error("busy late");
  property p_ready_pin;
    @(posedge clk_sys) disable iff (!rst_n)
      (fifoCount == '0 && !coreBusy && traceEmpty && !debugActive) [*2] |-> !serialOut_reg;
  endproperty
  a_ready_pin: assert property (p_ready_pin) else $error("ready pin high");
  property p_status_byte;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_reg == ST_ADDR_ACK && sclFall && rw_reg && i2cActive && !startDet && !stopDet
        && regPtr_reg == REG_DATA && !resultValid)
      |=> (txShift_reg == ($past(busyNow) ? STATUS_BUSY : STATUS_READY) && !resultTake_reg);
  endproperty
  a_status_byte: assert property (p_status_byte) else $error("bad status byte");
  property p_free_space;
    @(posedge clk_sys) disable iff (!rst_n)
      (state_reg == ST_ADDR_ACK && sclFall && rw_reg && i2cActive && !startDet && !stopDet
        && regPtr_reg == REG_CTRL)
      |=> (txShift_reg == DEPTH8 - 8'($past(fifoCount)));
  endproperty
  a_free_space: assert property (p_free_space) else $error("bad free count");
  property p_nan;
    @(posedge clk_sys) disable iff (!rst_n)
      deviceReset_reg |-> regInit_reg == NAN_INIT;
  endproperty
  a_nan: assert property (p_nan) else $error("init word not nan");
endmodule
`default_nettype wire

// *** coprocessor_host_serial_port_tb_top.sv ***
// Testbench: host model on the pins, core side driven by the bench.
// Assumes the design package and design modules are compiled first.
`timescale 1ns/1ps
`default_nettype none
module coprocessor_host_serial_port_tb_top;
  import fpu_port_pkg::*;
  logic clk_sys, rst_n, csPin, nvAddrValid, instrTake, resultValid;
  logic coreBusy, traceEmpty, debugActive, ack;
  logic [6:0] nvAddr, devAddr;
  logic [7:0] resultData, instrData, rdVal;
  logic sdaOut, sdaOe, serialOutPin, instrValid, resultTake, deviceReset, i2cMode;
  logic linkClk, hostSda;
  logic [31:0] regInitWord;
  wire logic sdaLine;
  int bad_count, total_checks, resetPulses, takePulses;
  assign sdaLine = sdaOe ? (sdaOut & hostSda) : hostSda;
  coprocessor_host_serial_port #(.SPI_RESET_COUNT(20), .DEPTH(32)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .linkClk(linkClk), .csPin(csPin),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .serialOutPin(serialOutPin),
    .nvAddr(nvAddr), .nvAddrValid(nvAddrValid), .instrData(instrData),
    .instrValid(instrValid), .instrTake(instrTake), .resultData(resultData),
    .resultValid(resultValid), .resultTake(resultTake), .coreBusy(coreBusy),
    .traceEmpty(traceEmpty), .debugActive(debugActive), .deviceReset(deviceReset),
    .regInitWord(regInitWord), .i2cMode(i2cMode)
  );
  host_master_model host_u (.linkClk(linkClk), .hostSda(hostSda), .sdaLine(sdaLine));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Core stand-in: counts pulses, drops a result once taken
  always @(posedge clk_sys) begin
    if (deviceReset === 1'b1) resetPulses <= resetPulses + 1;
    if (resultTake === 1'b1) begin
      takePulses <= takePulses + 1;
      resultValid <= 1'b0;
    end
  end
  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic doReset(input logic cs);
    @(negedge clk_sys);
    csPin = cs;
    rst_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask
  task automatic setCore(input logic dbg, input logic trc, input logic bsy);
    @(negedge clk_sys);
    debugActive = dbg;
    traceEmpty = trc;
    coreBusy = bsy;
  endtask
  task automatic sendAddr(input logic rd);
    host_u.i2cStart();
    host_u.byteXfer({devAddr, rd}, 1'b1, rdVal, ack);
  endtask
  task automatic regWrite(input logic [7:0] r, input logic [7:0] d);
    sendAddr(1'b0);
    checkVal(ack, 1'b1);
    host_u.byteXfer(r, 1'b1, rdVal, ack);
    host_u.byteXfer(d, 1'b1, rdVal, ack);
    checkVal(ack, 1'b1);
    host_u.i2cStop();
    repeat (6) @(negedge clk_sys);
  endtask
  task automatic regRead(input logic [7:0] r, input logic [7:0] exp);
    sendAddr(1'b0);
    host_u.byteXfer(r, 1'b1, rdVal, ack);
    host_u.i2cStop();
    sendAddr(1'b1);
    host_u.byteXfer(8'hff, 1'b1, rdVal, ack);
    host_u.i2cStop();
    checkVal(rdVal, exp);
  endtask
  task automatic scenBusy();
    checkVal(i2cMode, 1'b1);
    regWrite(REG_DATA, 8'h53);
    checkVal(instrData, 8'h53);
    checkVal(serialOutPin, 1'b1);
    regRead(REG_DATA, STATUS_BUSY);
    regRead(REG_CTRL, 8'(BUF_DEPTH - 1));
    @(negedge clk_sys);
    instrTake = 1'b1;
    @(negedge clk_sys);
    instrTake = 1'b0;
    repeat (4) @(negedge clk_sys);
    checkVal(serialOutPin, 1'b0);
    regRead(REG_DATA, STATUS_READY);
    setCore(1'b1, 1'b1, 1'b0);
    regRead(REG_DATA, STATUS_BUSY);
    setCore(1'b0, 1'b0, 1'b0);
    regRead(REG_DATA, STATUS_BUSY);
    setCore(1'b0, 1'b1, 1'b1);
    regRead(REG_DATA, STATUS_BUSY);
    setCore(1'b0, 1'b1, 1'b0);
  endtask
  task automatic scenResult();
    regRead(REG_DATA, STATUS_READY);
    @(negedge clk_sys);
    resultData = 8'ha5;
    resultValid = 1'b1;
    regRead(REG_DATA, 8'ha5);
    checkVal(takePulses, 1);
    regRead(REG_DATA, STATUS_READY);
  endtask
  task automatic scenAddr();
    regWrite(8'h05, 8'h12);
    regRead(8'h05, OTHER_READ);
    regRead(REG_CTRL, 8'(BUF_DEPTH));
    devAddr = 7'h22;
    sendAddr(1'b0);
    host_u.i2cStop();
    checkVal(ack, 1'b0);
    @(negedge clk_sys);
    nvAddr = 7'h22;
    nvAddrValid = 1'b1;
    repeat (3) @(negedge clk_sys);
    nvAddrValid = 1'b0;
    regWrite(8'h05, 8'h00);
    regRead(REG_CTRL, 8'(BUF_DEPTH));
  endtask
  task automatic scenReset();
    regWrite(REG_DATA, 8'h01);
    regWrite(REG_CTRL, 8'h07);
    checkVal(resetPulses, 0);
    regWrite(REG_CTRL, RESET_BYTE);
    checkVal(resetPulses, 1);
    checkVal(regInitWord, NAN_INIT);
    regRead(REG_CTRL, 8'(BUF_DEPTH));
  endtask
  task automatic scenSpi();
    host_u.linkSet(1'b0, 1'b0);
    doReset(1'b0);
    checkVal(i2cMode, 1'b0);
    host_u.spiByte(8'h8e);
    repeat (6) @(negedge clk_sys);
    checkVal(instrData, 8'h8e);
    checkVal(serialOutPin, 1'b1);
    host_u.linkSet(1'b1, 1'b0);
    repeat (10) @(negedge clk_sys);
    host_u.linkSet(1'b0, 1'b0);
    repeat (5) @(negedge clk_sys);
    checkVal(resetPulses, 1);
    host_u.linkSet(1'b1, 1'b0);
    repeat (40) @(negedge clk_sys);
    checkVal(resetPulses, 1);
    host_u.linkSet(1'b0, 1'b0);
    repeat (5) @(negedge clk_sys);
    checkVal(resetPulses, 2);
    checkVal(instrValid, 1'b0);
  endtask
  initial begin
    {rst_n, csPin, nvAddrValid, instrTake, resultValid, coreBusy, debugActive} = '0;
    traceEmpty = 1'b1;
    nvAddr = 7'h00;
    resultData = 8'h00;
    devAddr = I2C_ADDR_DEFAULT;
    {bad_count, total_checks, resetPulses, takePulses} = '0;
    doReset(1'b1);
    scenBusy();
    scenResult();
    scenAddr();
    scenReset();
    scenSpi();
    print_verdict();
  end
  initial begin
    #500000;
    bad_count++;
    print_verdict();
  end
endmodule
`default_nettype wire

// *** fpu_port_pkg.sv ***
// Shared constants, types and timing counts for the coprocessor host port.
// Assumes a 100 MHz system clock; host clocks arrive on pins.
// Summary of operation
// - Select pin high at reset: I2C slave.
// - Select pin low at reset: SPI slave.
// - Seven-bit address plus direction bit, default 0x64.
// - Slave address changeable, kept nonvolatile.
// - Write: address, register byte, data bytes, acked.
// - Register 0 writes feed instruction buffer.
// - Register 0 read: result byte else status.
// - Status byte 0x00 ready, 0x80 busy.
// - Busy rises as soon as opcode arrives.
// - Ready only with both buffers empty.
// - Zero byte to register 1 resets device.
// - Register 1 read gives free buffer bytes.
// - Reset loads data registers with quiet NaN.
// - Host delays 90/180 us after read opcode.
// - SPI: input low, clock high 500 us.
// - SPI reset fires when clock returns low.
// - SPI mode 0, most significant bit first.
// - SPI serial output low ready, high busy.
package fpu_port_pkg;
  localparam logic [7:0] REG_DATA = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h01;
  localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h64;
  localparam logic [7:0] STATUS_READY = 8'h00;
  localparam logic [7:0] STATUS_BUSY = 8'h80;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] OTHER_READ = 8'h00;
  localparam logic [31:0] NAN_INIT = 32'h7fc00000;
  localparam int BUF_DEPTH = 32;
  localparam int CLK_SYS_MHZ = 100;
  localparam int SPI_RESET_US = 500;
  localparam int SPI_RESET_CYCLES = SPI_RESET_US * CLK_SYS_MHZ;
  localparam int RESET_WAIT_MS = 8;
  localparam int READ_DELAY_US = 90;
  localparam int READ_DELAY_DEBUG_US = 180;
  localparam int SYNC_CS = 0;
  localparam int SYNC_SCL = 1;
  localparam int SYNC_SDA = 2;
  localparam int SYNC_TOG = 3;
  localparam int SYNC_W = 4;
  localparam logic [1:0] MODE_WAIT_TAKE = 2'h2;
  localparam logic [1:0] MODE_WAIT_DONE = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR_ACK = 3'h3,
    ST_RXB = 3'h2,
    ST_RXACK = 3'h6,
    ST_TXB = 3'h7,
    ST_TXACK = 3'h5
  } i2c_state_e;
endpackage

// *** host_master_model.sv ***
// Host master model: drives link clock and data pin as I2C or SPI master.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module host_master_model (
  output logic linkClk,
  output logic hostSda,
  input wire logic sdaLine
);
  initial begin
    linkClk = 1'b0;
    hostSda = 1'b1;
  end
  task automatic linkSet(input logic c, input logic d);
    linkClk = c;
    hostSda = d;
  endtask
  task automatic i2cStart();
    hostSda = 1'b1;
    #50 linkClk = 1'b1;
    #63 hostSda = 1'b0;
    #63 linkClk = 1'b0;
  endtask
  task automatic i2cStop();
    #20 hostSda = 1'b0;
    #63 linkClk = 1'b1;
    #63 hostSda = 1'b1;
    #63;
  endtask
  task automatic bitXfer(input logic b, output logic r);
    #20 hostSda = b;
    #30 linkClk = 1'b1;
    #31 r = sdaLine;
    #31 linkClk = 1'b0;
    #13;
  endtask
  // Eight bits then the acknowledge slot
  task automatic byteXfer(input logic [7:0] tx, input logic ackIn,
                          output logic [7:0] rx, output logic ackOut);
    logic a;
    for (int i = 7; i >= 0; i--) bitXfer(tx[i], rx[i]);
    bitXfer(ackIn, a);
    ackOut = ~a;
  endtask
  task automatic spiByte(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      hostSda = tx[i];
      #62 linkClk = 1'b1;
      #63 linkClk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// *** instr_buffer.sv ***
// Instruction byte buffer in flip-flops with occupancy count.
// Assumes DEPTH is a power of two; writes while full are dropped.
`timescale 1ns/1ps
`default_nettype none
module instr_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = AW + 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic wrValid,
  output logic [WIDTH-1:0] rdData,
  output logic rdValid,
  input wire logic rdReady,
  output logic [CW-1:0] count
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [CW-1:0] count_reg;
  logic put;
  logic take;
  assign take = rdValid & rdReady;
  assign put = wrValid & (count_reg != CW'(DEPTH));
  assign rdValid = (count_reg != '0);
  assign rdData = mem[rdPtr_reg];
  assign count = count_reg;
  always_ff @(posedge clk) begin
    if (put) begin
      mem[wrPtr_reg] <= wrData;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (put) begin
        wrPtr_reg <= wrPtr_reg + AW'(1);
      end
      if (take) begin
        rdPtr_reg <= rdPtr_reg + AW'(1);
      end
      if (put && !take) begin
        count_reg <= count_reg + CW'(1);
      end else if (take && !put) begin
        count_reg <= count_reg - CW'(1);
      end
    end
  end
endmodule
`default_nettype wire

// *** sync_2ff.sv ***
// Two flip-flop level synchroniser, one stage pair per bit.
// Assumes inputs are levels that stay stable for several clocks.
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_reg[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_reg[i] <= d[i];
          q[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire
